// >>> hdl/scalar_pipeline_control.sv
// Five-stage scalar pipeline control: decode, branch timing and load interlock.
`default_nettype none
module scalar_pipeline_control (
    // Clock, reset and enable.
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic I_CE,
    // Fetch side.
    input wire logic [pipe_pkg::INST_W-1:0] I_SCALAR_UNIT_INST,
    input wire logic I_SCALAR_UNIT_INST_VLD,
    output logic [31:0] O_PC,
    // Register operands: rs of the decoding instruction, rs and rt of the executing one.
    input wire logic [31:0] I_RD_RS_VAL,
    input wire logic [31:0] I_EX_RS_VAL,
    input wire logic [31:0] I_EX_RT_VAL,
    // Execute stage status.
    output logic O_EX_VLD,
    output logic [pipe_pkg::INST_W-1:0] O_EX_INST,
    output logic O_BR_TAKEN,
    output logic O_ILLEGAL,
    output logic O_BREAK,
    output logic O_STALLED,
    // Memory access and write back.
    output logic O_MEM_RD,
    output logic O_MEM_WR,
    output logic O_MEM_VEC,
    output logic O_WB_WE,
    output logic [4:0] O_WB_REG
);
    import pipe_pkg::*;

    hazard_if hz ();

    logic [31:0] pc_r;
    logic [31:0] rd_inst_r;
    logic [15:0] rd_pc_r;
    logic rd_vld_r;
    logic [31:0] ex_inst_r;
    logic [15:0] ex_pc_r;
    logic ex_vld_r;
    class_e ex_class_r;
    logic [4:0] ex_dest_r;
    logic ex_we_r;
    logic mem_vld_r;
    logic mem_load_r;
    logic [4:0] mem_dest_r;
    logic mem_we_r;
    logic taken_r;
    logic illegal_r;
    logic break_r;
    logic stall_r;
    logic mem_rd_r;
    logic mem_wr_r;
    logic mem_vec_r;
    logic wb_we_r;
    logic [4:0] wb_reg_r;
    class_e rd_class;
    logic [4:0] rd_dest;
    logic rd_we;
    logic [15:0] tgt;
    logic redirect;
    logic br_cond;
    logic taken;
    logic not_taken;
    logic [31:0] refetch_pc;
    logic stall;

    // =========================================================
    // Decode
    function automatic class_e decode(input logic [31:0] w);
        logic [5:0] op;
        logic [5:0] fn;
        logic [4:0] rs;
        logic [4:0] rt;
        op = w[31:26];
        fn = w[5:0];
        rs = w[25:21];
        rt = w[20:16];
        decode = CL_BAD;
        case (op)
            OP_SPECIAL: begin
                case (fn)
                    FN_SLL, FN_SRL, FN_SRA, FN_SLLV, FN_SRLV, FN_SRAV, FN_SLT,
                    FN_SLTU: decode = CL_ALU_R;
                    FN_JR, FN_JALR: decode = CL_JREG;
                    FN_BREAK: decode = CL_BREAK;
                    default: decode = (fn >= FN_ADD && fn <= FN_NOR) ? CL_ALU_R : CL_BAD;
                endcase
            end
            OP_REGIMM: decode = (rt[3:1] == 3'h0) ? CL_BRANCH : CL_BAD;
            OP_J, OP_JAL: decode = CL_JUMP;
            OP_BEQ, OP_BNE, OP_BLEZ, OP_BGTZ: decode = CL_BRANCH;
            OP_LUI: decode = CL_LUI;
            OP_LB, OP_LH, OP_LW, OP_LBU, OP_LHU: decode = CL_LOAD;
            OP_SB, OP_SH, OP_SW: decode = CL_STORE;
            OP_VLOAD: decode = CL_VLOAD;
            OP_VSTORE: decode = CL_VSTORE;
            default: begin
                if (op >= OP_ADDI && op <= OP_XORI) begin
                    decode = CL_ALU_I;
                end else if (op[5:2] == OP_COP_HI) begin
                    if (rs == CP_MOVE_FROM || rs == CP_CTRL_FROM) begin
                        decode = CL_CP_FROM;
                    end else if (rs == CP_MOVE_TO || rs == CP_CTRL_TO) begin
                        decode = CL_CP_TO;
                    end
                end
            end
        endcase
    endfunction : decode

    always_comb begin
        rd_class = decode(rd_inst_r);
        rd_dest = rd_inst_r[20:16];
        rd_we = 1'b0;
        case (rd_class)
            CL_ALU_R: begin
                rd_dest = rd_inst_r[15:11];
                rd_we = 1'b1;
            end
            CL_JREG: begin
                rd_dest = rd_inst_r[15:11];
                rd_we = (rd_inst_r[5:0] == FN_JALR);
            end
            CL_JUMP: begin
                rd_dest = LINK_REG;
                rd_we = (rd_inst_r[31:26] == OP_JAL);
            end
            CL_BRANCH: begin
                rd_dest = LINK_REG;
                rd_we = (rd_inst_r[31:26] == OP_REGIMM) && rd_inst_r[20];
            end
            CL_ALU_I, CL_LUI, CL_LOAD, CL_CP_FROM: rd_we = 1'b1;
            default: rd_we = 1'b0;
        endcase
    end

    // =========================================================
    // Targets and branch resolution
    always_comb begin
        case (rd_class)
            CL_JUMP: tgt = {rd_inst_r[13:0], 2'b00};
            CL_JREG: tgt = {I_RD_RS_VAL[15:2], 2'b00};
            default: tgt = rd_pc_r + PC_STEP + {rd_inst_r[13:0], 2'b00};
        endcase
        redirect = rd_vld_r && !stall &&
            (rd_class == CL_BRANCH || rd_class == CL_JUMP || rd_class == CL_JREG);
        case (ex_inst_r[31:26])
            OP_BEQ: br_cond = (I_EX_RS_VAL == I_EX_RT_VAL);
            OP_BNE: br_cond = (I_EX_RS_VAL != I_EX_RT_VAL);
            OP_BLEZ: br_cond = I_EX_RS_VAL[31] || (I_EX_RS_VAL == 32'h0000_0000);
            OP_BGTZ: br_cond = !I_EX_RS_VAL[31] && (I_EX_RS_VAL != 32'h0000_0000);
            default: br_cond = (I_EX_RS_VAL[31] != ex_inst_r[16]);
        endcase
        taken = ex_vld_r && (ex_class_r == CL_BRANCH) && br_cond;
        not_taken = ex_vld_r && (ex_class_r == CL_BRANCH) && !br_cond;
        refetch_pc = {16'h0000, ex_pc_r + REFETCH_STEP};
    end

    // =========================================================
    // Interlock
    assign hz.rd_vld = rd_vld_r;
    assign hz.rd_rs = rd_inst_r[25:21];
    assign hz.rd_rt = rd_inst_r[20:16];
    assign hz.rd_chk_rt = !(rd_class == CL_VLOAD || rd_class == CL_VSTORE ||
        rd_class == CL_ALU_I || rd_class == CL_LUI || rd_class == CL_LOAD);
    assign hz.ex_pend = ex_vld_r && (ex_class_r == CL_LOAD || ex_class_r == CL_CP_FROM);
    assign hz.ex_dest = ex_dest_r;
    assign hz.mem_pend = mem_vld_r && mem_load_r;
    assign hz.mem_dest = mem_dest_r;
    assign stall = hz.stall;

    load_interlock u_interlock (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .hz(hz)
    );

    // =========================================================
    // Fetch and decode stages
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pc_r <= PC_RESET;
        end else if (I_CE) begin
            if (not_taken) begin
                pc_r <= refetch_pc;
            end else if (stall) begin
                pc_r <= pc_r;
            end else if (redirect) begin
                pc_r <= {16'h0000, tgt};
            end else begin
                pc_r <= {16'h0000, pc_r[15:0] + PC_STEP};
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rd_vld_r <= 1'b0;
            rd_inst_r <= 32'h0000_0000;
            rd_pc_r <= 16'h0000;
        end else if (I_CE && !stall) begin
            rd_vld_r <= I_SCALAR_UNIT_INST_VLD && !not_taken;
            rd_inst_r <= I_SCALAR_UNIT_INST;
            rd_pc_r <= pc_r[15:0];
        end
    end

    // =========================================================
    // Execute, memory access and write back stages
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ex_vld_r <= 1'b0;
            ex_inst_r <= 32'h0000_0000;
            ex_pc_r <= 16'h0000;
            ex_class_r <= CL_BAD;
            ex_dest_r <= 5'h00;
            ex_we_r <= 1'b0;
        end else if (I_CE) begin
            ex_vld_r <= rd_vld_r && !stall;
            ex_inst_r <= rd_inst_r;
            ex_pc_r <= rd_pc_r;
            ex_class_r <= rd_class;
            ex_dest_r <= rd_dest;
            ex_we_r <= rd_we;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mem_vld_r <= 1'b0;
            mem_load_r <= 1'b0;
            mem_dest_r <= 5'h00;
            mem_we_r <= 1'b0;
            mem_rd_r <= 1'b0;
            mem_wr_r <= 1'b0;
            mem_vec_r <= 1'b0;
            wb_we_r <= 1'b0;
            wb_reg_r <= 5'h00;
        end else if (I_CE) begin
            mem_vld_r <= ex_vld_r && ex_class_r != CL_BAD;
            mem_load_r <= ex_class_r == CL_LOAD || ex_class_r == CL_CP_FROM;
            mem_dest_r <= ex_dest_r;
            mem_we_r <= ex_vld_r && ex_we_r;
            mem_rd_r <= ex_vld_r && (ex_class_r == CL_LOAD || ex_class_r == CL_VLOAD);
            mem_wr_r <= ex_vld_r && (ex_class_r == CL_STORE || ex_class_r == CL_VSTORE);
            mem_vec_r <= ex_vld_r && (ex_class_r == CL_VLOAD || ex_class_r == CL_VSTORE);
            wb_we_r <= mem_vld_r && mem_we_r;
            wb_reg_r <= mem_dest_r;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            taken_r <= 1'b0;
            illegal_r <= 1'b0;
            break_r <= 1'b0;
            stall_r <= 1'b0;
        end else if (I_CE) begin
            taken_r <= taken;
            illegal_r <= ex_vld_r && (ex_class_r == CL_BAD);
            break_r <= ex_vld_r && (ex_class_r == CL_BREAK);
            stall_r <= stall;
        end
    end

    assign O_PC = pc_r;
    assign O_EX_VLD = ex_vld_r;
    assign O_EX_INST = ex_inst_r;
    assign O_BR_TAKEN = taken_r;
    assign O_ILLEGAL = illegal_r;
    assign O_BREAK = break_r;
    assign O_STALLED = stall_r;
    assign O_MEM_RD = mem_rd_r;
    assign O_MEM_WR = mem_wr_r;
    assign O_MEM_VEC = mem_vec_r;
    assign O_WB_WE = wb_we_r;
    assign O_WB_REG = wb_reg_r;

    // =========================================================
    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN || !I_CE);

    sequence s_not_taken;
        not_taken;
    endsequence
    // A stall in the resolving cycle keeps the valid delay slot in decode.
    sequence s_refetch;
        O_PC == $past(refetch_pc) && rd_vld_r == $past(stall);
    endsequence

    a_pc_zero_bits: assert property (O_PC[31:16] == 16'h0000 && O_PC[1:0] == 2'b00)
        else $error("pc reserved bits set");
    a_notaken_refetch: assert property (s_not_taken |=> s_refetch)
        else $error("not-taken branch did not refetch");
    a_redirect_target: assert property (redirect && !not_taken |=>
        O_PC == {16'h0000, $past(tgt)}) else $error("redirect missed target");
    a_taken_flows: assert property (taken && !stall |=>
        rd_vld_r == $past(I_SCALAR_UNIT_INST_VLD)) else $error("taken branch dropped target");
    a_delay_slot_runs: assert property (ex_vld_r && ex_class_r == CL_BRANCH &&
        rd_vld_r && !stall |=> ex_vld_r) else $error("delay slot lost");
    a_stall_bubble: assert property (stall |=> !ex_vld_r && $stable(rd_inst_r))
        else $error("stall did not hold and bubble");
    a_unsupported_flag: assert property (ex_vld_r && ex_class_r == CL_BAD |=> O_ILLEGAL)
        else $error("unsupported not flagged");
    a_load_two_cycles: assert property (hz.ex_pend && rd_vld_r && hz.ex_dest == hz.rd_rs
        |-> stall ##1 stall) else $error("load delay not two cycles");
endmodule : scalar_pipeline_control
`default_nettype wire

// >>> shared/pipe_pkg.sv
// Constants, encodings and decode classes shared by the scalar pipeline control.
`default_nettype none
package pipe_pkg;
    localparam int unsigned INST_W = 32;
    localparam int unsigned REG_W = 5;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [15:0] PC_STEP = 16'h0004;
    localparam logic [15:0] REFETCH_STEP = 16'h0008;
    localparam logic [4:0] LINK_REG = 5'h1F;
    // Primary opcodes.
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_REGIMM = 6'h01;
    localparam logic [5:0] OP_J = 6'h02;
    localparam logic [5:0] OP_JAL = 6'h03;
    localparam logic [5:0] OP_BEQ = 6'h04;
    localparam logic [5:0] OP_BNE = 6'h05;
    localparam logic [5:0] OP_BLEZ = 6'h06;
    localparam logic [5:0] OP_BGTZ = 6'h07;
    localparam logic [5:0] OP_ADDI = 6'h08;
    localparam logic [5:0] OP_XORI = 6'h0E;
    localparam logic [5:0] OP_LUI = 6'h0F;
    localparam logic [3:0] OP_COP_HI = 4'h4;
    localparam logic [5:0] OP_LB = 6'h20;
    localparam logic [5:0] OP_LH = 6'h21;
    localparam logic [5:0] OP_LW = 6'h23;
    localparam logic [5:0] OP_LBU = 6'h24;
    localparam logic [5:0] OP_LHU = 6'h25;
    localparam logic [5:0] OP_SB = 6'h28;
    localparam logic [5:0] OP_SH = 6'h29;
    localparam logic [5:0] OP_SW = 6'h2B;
    localparam logic [5:0] OP_VLOAD = 6'h32;
    localparam logic [5:0] OP_VSTORE = 6'h3A;
    // Function codes of register type.
    localparam logic [5:0] FN_SLL = 6'h00;
    localparam logic [5:0] FN_SRL = 6'h02;
    localparam logic [5:0] FN_SRA = 6'h03;
    localparam logic [5:0] FN_SLLV = 6'h04;
    localparam logic [5:0] FN_SRLV = 6'h06;
    localparam logic [5:0] FN_SRAV = 6'h07;
    localparam logic [5:0] FN_JR = 6'h08;
    localparam logic [5:0] FN_JALR = 6'h09;
    localparam logic [5:0] FN_BREAK = 6'h0D;
    localparam logic [5:0] FN_ADD = 6'h20;
    localparam logic [5:0] FN_NOR = 6'h27;
    localparam logic [5:0] FN_SLT = 6'h2A;
    localparam logic [5:0] FN_SLTU = 6'h2B;
    // Coprocessor sub-opcodes in the rs field.
    localparam logic [4:0] CP_MOVE_FROM = 5'h00;
    localparam logic [4:0] CP_CTRL_FROM = 5'h02;
    localparam logic [4:0] CP_MOVE_TO = 5'h04;
    localparam logic [4:0] CP_CTRL_TO = 5'h06;
    typedef enum logic [3:0] {
        CL_BAD, CL_ALU_R, CL_ALU_I, CL_LUI, CL_LOAD, CL_STORE, CL_BRANCH, CL_JUMP,
        CL_JREG, CL_BREAK, CL_CP_FROM, CL_CP_TO, CL_VLOAD, CL_VSTORE
    } class_e;
endpackage : pipe_pkg
`default_nettype wire

// >>> shared/hazard_if.sv
// Signals between the pipeline control and its load-delay interlock unit.
`default_nettype none
interface hazard_if;
    logic rd_vld;
    logic [4:0] rd_rs;
    logic [4:0] rd_rt;
    logic rd_chk_rt;
    logic ex_pend;
    logic [4:0] ex_dest;
    logic mem_pend;
    logic [4:0] mem_dest;
    logic stall;
    modport pipe (output rd_vld, rd_rs, rd_rt, rd_chk_rt, ex_pend, ex_dest, mem_pend,
        mem_dest, input stall);
    modport unit (input rd_vld, rd_rs, rd_rt, rd_chk_rt, ex_pend, ex_dest, mem_pend,
        mem_dest, output stall);
endinterface : hazard_if
`default_nettype wire

// >>> hdl/load_interlock.sv
// Load-delay interlock detector for the scalar pipeline.
`default_nettype none
module load_interlock (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Pipeline view.
    hazard_if.unit hz
);
    logic hit_ex;
    logic hit_mem;

    // =========================================================
    // Field comparison
    always_comb begin
        hit_ex = hz.ex_pend && ((hz.ex_dest == hz.rd_rs) ||
            (hz.rd_chk_rt && (hz.ex_dest == hz.rd_rt)));
        hit_mem = hz.mem_pend && ((hz.mem_dest == hz.rd_rs) ||
            (hz.rd_chk_rt && (hz.mem_dest == hz.rd_rt)));
        hz.stall = hz.rd_vld && (hit_ex || hit_mem);
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_rs_match_stall: assert property (hz.rd_vld && hz.ex_pend && hz.ex_dest == hz.rd_rs
        |-> hz.stall) else $error("rs match did not stall");
    a_rt_skip_unchk: assert property (hz.rd_vld && !hz.rd_chk_rt &&
        !(hz.ex_pend && hz.ex_dest == hz.rd_rs) && !(hz.mem_pend && hz.mem_dest == hz.rd_rs)
        |-> !hz.stall) else $error("unchecked rt caused stall");
    a_no_pend_nostall: assert property (!hz.ex_pend && !hz.mem_pend |-> !hz.stall)
        else $error("stall without pending load");
endmodule : load_interlock
`default_nettype wire

// >>> dv/inst_ram_model.sv
// Instruction RAM model that answers fetches from the scalar pipeline control.
`default_nettype none
module inst_ram_model (
    // Clock.
    input wire logic i_clk,
    // Fetch port.
    input wire logic [31:0] i_pc,
    output logic [31:0] o_inst,
    output logic o_vld
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:63];
    logic ok [0:63] = '{default: 1'b0};
    logic [31:0] noise_r = 32'h5A3C_96E1;
    // Words that are not valid show a pattern that changes every cycle.
    always @(posedge i_clk) noise_r <= {noise_r[30:0], ~noise_r[31]};
    assign o_vld = ok[i_pc[7:2]];
    assign o_inst = o_vld ? mem[i_pc[7:2]] : noise_r;
endmodule : inst_ram_model
`default_nettype wire

// >>> dv/scalar_pipeline_control_tb_top.sv
// Self-checking bench for the scalar pipeline control.
`default_nettype none
module scalar_pipeline_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pipe_pkg::*;
    // ==========================================
    // Signals and instances
    localparam int NTR = 24;
    localparam logic [8:0] F_VLD = 9'h100;
    localparam logic [8:0] F_BR = 9'h080;
    localparam logic [8:0] F_ILL = 9'h040;
    localparam logic [8:0] F_BRK = 9'h020;
    localparam logic [8:0] F_STL = 9'h010;
    localparam logic [8:0] F_MRD = 9'h008;
    localparam logic [8:0] F_MWR = 9'h004;
    localparam logic [8:0] F_VEC = 9'h002;
    localparam logic [8:0] F_WB = 9'h001;
    localparam logic [8:0] F_MEM = 9'h00E;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [31:0] rd_rs = 32'h0;
    logic [31:0] ex_rs = 32'h0;
    logic [31:0] ex_rt = 32'h0;
    logic [31:0] inst, pc, ex_inst;
    logic inst_vld, ex_vld, br, ill, brk, stl, mrd, mwr, mvec, wbwe;
    logic [4:0] wbreg;
    logic [8:0] flags;
    logic [31:0] t_inst [0:NTR-1];
    logic [31:0] t_pc [0:NTR-1];
    logic [8:0] t_fl [0:NTR-1];
    logic [4:0] t_wb [0:NTR-1];
    int n_mismatch = 0;
    int n_compared = 0;
    assign flags = {ex_vld, br, ill, brk, stl, mrd, mwr, mvec, wbwe};
    always #2.5 clk = ~clk;
    scalar_pipeline_control DUT (.I_CLK(clk), .I_RESETN(resetn), .I_CE(ce),
        .I_SCALAR_UNIT_INST(inst), .I_SCALAR_UNIT_INST_VLD(inst_vld),
        .O_PC(pc), .I_RD_RS_VAL(rd_rs),
        .I_EX_RS_VAL(ex_rs), .I_EX_RT_VAL(ex_rt), .O_EX_VLD(ex_vld), .O_EX_INST(ex_inst),
        .O_BR_TAKEN(br), .O_ILLEGAL(ill), .O_BREAK(brk), .O_STALLED(stl), .O_MEM_RD(mrd),
        .O_MEM_WR(mwr), .O_MEM_VEC(mvec), .O_WB_WE(wbwe), .O_WB_REG(wbreg));
    inst_ram_model u_ram (.i_clk(clk), .i_pc(pc), .o_inst(inst), .o_vld(inst_vld));
    // ==========================================
    // Helpers
    function automatic logic [31:0] ri(input logic [5:0] op, input logic [4:0] rs,
        input logic [4:0] rt, input logic [15:0] imm);
        return {op, rs, rt, imm};
    endfunction : ri
    function automatic logic [31:0] rr(input logic [4:0] rs, input logic [4:0] rt,
        input logic [4:0] rd, input logic [5:0] fn);
        return {OP_SPECIAL, rs, rt, rd, 5'h00, fn};
    endfunction : rr
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic ex(input int k, input logic [31:0] w);
        chk("ex_valid", t_fl[k][8], 1'b1);
        chk("ex_inst", t_inst[k], w);
    endtask : ex
    task automatic bub(input int k);
        chk("ex_bubble", t_fl[k][8], 1'b0);
    endtask : bub
    task automatic chk_fl(input int k, input logic [8:0] m, input logic [8:0] e);
        chk("flags", t_fl[k] & m, e);
    endtask : chk_fl
    // Resets the core, loads a program and records one sample per cycle.
    task automatic run(input logic [31:0] p [$], input logic pad, input logic [31:0] rsv,
        input logic [31:0] rtv, input logic [31:0] jrv);
        @(posedge clk);
        #1;
        resetn = 1'b0;
        ex_rs = rsv;
        ex_rt = rtv;
        rd_rs = jrv;
        for (int i = 0; i < 64; i++) begin
            u_ram.mem[i] = 32'h0000_0000;
            u_ram.ok[i] = pad;
        end
        foreach (p[i]) begin
            u_ram.mem[i] = p[i];
            u_ram.ok[i] = 1'b1;
        end
        @(posedge clk);
        #1;
        chk("reset_pc", pc, 32'h0000_0000);
        chk("reset_flags", flags, 9'h000);
        resetn = 1'b1;
        // Skip the half cycle before the first enabled edge: sample k follows edge k + 1.
        @(negedge clk);
        for (int k = 0; k < NTR; k++) begin
            @(negedge clk);
            t_inst[k] = ex_inst;
            t_pc[k] = pc;
            t_fl[k] = flags;
            t_wb[k] = wbreg;
            chk("pc_fixed_bits", {pc[31:16], pc[1:0]}, 18'h00000);
        end
    endtask : run
    // ==========================================
    // Scenarios
    task automatic t_branch;
        logic [31:0] p [$];
        p = '{ri(OP_BEQ, 1, 2, 16'h0003), ri(OP_ADDI, 0, 3, 16'h0011),
            ri(OP_ADDI, 0, 4, 16'h0022), ri(OP_ADDI, 0, 5, 16'h0033),
            ri(OP_XORI, 0, 6, 16'h0044), ri(OP_XORI, 0, 7, 16'h0055)};
        run(p, 1'b1, 32'h0000_0005, 32'h0000_0005, 32'h0);
        chk("pc", t_pc[0], 32'h0000_0004);
        chk("pc", t_pc[1], 32'h0000_0010);
        ex(1, p[0]);
        ex(2, p[1]);
        ex(3, p[4]);
        ex(4, p[5]);
        chk_fl(2, F_BR, F_BR);
        run(p, 1'b1, 32'h0000_0005, 32'h0000_0006, 32'h0);
        ex(2, p[1]);
        bub(3);
        ex(4, p[2]);
        ex(5, p[3]);
        chk("pc", t_pc[2], 32'h0000_0008);
        chk_fl(2, F_BR, 9'h000);
        $display("test branch done");
    endtask : t_branch
    task automatic t_jump;
        logic [31:0] p [$];
        logic [31:0] m;
        m = ri(OP_XORI, 0, 9, 16'h0BAD);
        p = '{{OP_J, 26'h0000005}, ri(OP_ADDI, 0, 3, 16'h0001), m, m, m, rr(3, 0, 0, FN_JR),
            ri(OP_ADDI, 0, 4, 16'h0002), m, m, m, m, m, ri(OP_XORI, 0, 5, 16'h0077)};
        run(p, 1'b1, 32'h0, 32'h0, 32'hFFFF_0033);
        ex(1, p[0]);
        ex(2, p[1]);
        ex(3, p[5]);
        chk("pc", t_pc[1], 32'h0000_0014);
        ex(4, p[6]);
        ex(5, p[12]);
        chk("pc", t_pc[3], 32'h0000_0030);
        $display("test jump done");
    endtask : t_jump
    task automatic t_interlock;
        logic [31:0] p [$];
        int ix [$];
        p = '{ri(OP_LW, 1, 5, 16'h0), rr(5, 2, 6, FN_ADD), ri(OP_LW, 1, 7, 16'h0), 32'h0,
            rr(0, 7, 8, FN_ADD), ri(OP_LW, 1, 9, 16'h0), ri(OP_ADDI, 0, 9, 16'h0001),
            ri(OP_LW, 1, 11, 16'h0), ri(OP_VLOAD, 0, 11, 16'h0), 32'h0,
            {OP_COP_HI, 2'h2, CP_MOVE_FROM, 5'h04, 5'h02, 11'h000},
            {OP_COP_HI, 2'h2, CP_MOVE_TO, 5'h00, 5'h08, 11'h000}};
        ix = '{0, -1, -1, 1, 2, 3, -1, 4, 5, 6, 7, 8, 9, 10, -1, -1, 11};
        run(p, 1'b1, 32'h0, 32'h0, 32'h0);
        foreach (ix[k]) begin
            if (ix[k] < 0) begin
                bub(k + 1);
            end else begin
                ex(k + 1, p[ix[k]]);
            end
        end
        chk_fl(2, F_STL, F_STL);
        chk_fl(3, F_STL, F_STL);
        chk_fl(4, F_STL, 9'h000);
        chk("pc", t_pc[3], 32'h0000_0008);
        $display("test interlock done");
    endtask : t_interlock
    task automatic t_memory;
        logic [31:0] p [$];
        p = '{ri(OP_LW, 1, 5, 16'h0), ri(OP_SW, 1, 2, 16'h0), ri(OP_VLOAD, 1, 3, 16'h0800),
            ri(OP_VSTORE, 1, 4, 16'h0), {OP_JAL, 26'h0000008}};
        run(p, 1'b1, 32'h0, 32'h0, 32'h0);
        chk_fl(2, F_MEM, F_MRD);
        chk_fl(3, F_WB, F_WB);
        chk("wb_reg", t_wb[3], 5'h05);
        chk_fl(3, F_MEM, F_MWR);
        chk_fl(4, F_MEM, F_MRD | F_VEC);
        chk_fl(4, F_WB, 9'h000);
        chk_fl(5, F_MEM, F_MWR | F_VEC);
        chk_fl(7, F_WB, F_WB);
        chk("wb_reg", t_wb[7], 5'h1F);
        $display("test memory done");
    endtask : t_memory
    task automatic t_decode;
        logic [31:0] p [$];
        p = '{rr(0, 0, 0, 6'h0C), rr(1, 2, 0, 6'h18), rr(1, 2, 0, 6'h1A),
            {6'h12, 5'h08, 5'h00, 16'h0}, {6'h12, 5'h08, 5'h01, 16'h0}, rr(0, 0, 0, FN_BREAK),
            rr(1, 2, 3, FN_ADD), ri(OP_LUI, 0, 3, 16'h1234), ri(OP_XORI, 1, 3, 16'h00FF),
            rr(1, 2, 3, FN_SLT), rr(1, 2, 3, FN_NOR), rr(1, 2, 3, FN_SRAV),
            ri(OP_LHU, 1, 3, 16'h0)};
        run(p, 1'b0, 32'h0, 32'h0, 32'h0);
        foreach (p[i]) begin
            chk_fl(i + 2, F_ILL | F_BRK, (i < 5) ? F_ILL : ((i == 5) ? F_BRK : 9'h000));
            ex(i + 1, p[i]);
        end
        bub(14);
        chk_fl(15, F_ILL, 9'h000);
        $display("test decode done");
    endtask : t_decode
    task automatic t_cond;
        logic [31:0] p [$];
        logic [31:0] m;
        m = ri(OP_XORI, 0, 9, 16'h0BAD);
        p = '{ri(OP_REGIMM, 1, 5'h11, 16'h0002), ri(OP_ADDI, 0, 3, 16'h0001),
            ri(OP_REGIMM, 1, 5'h00, 16'h0003), ri(OP_ADDI, 0, 4, 16'h0002), m, m,
            ri(OP_XORI, 0, 5, 16'h0066)};
        run(p, 1'b1, 32'hFFFF_FFFF, 32'h0, 32'h0);
        ex(1, p[0]);
        chk_fl(2, F_BR, 9'h000);
        chk("pc", t_pc[2], 32'h0000_0008);
        ex(2, p[1]);
        bub(3);
        chk_fl(3, F_WB, F_WB);
        chk("wb_reg", t_wb[3], 5'h1F);
        ex(4, p[2]);
        ex(5, p[3]);
        chk_fl(5, F_BR, F_BR);
        ex(6, p[6]);
        $display("test conditional done");
    endtask : t_cond
    task automatic t_enable;
        logic [31:0] p [$];
        logic [31:0] pc0;
        logic [8:0] fl0;
        p = '{ri(OP_ADDI, 0, 3, 16'h0001)};
        run(p, 1'b1, 32'h0, 32'h0, 32'h0);
        @(posedge clk);
        #1;
        ce = 1'b0;
        pc0 = pc;
        fl0 = flags;
        repeat (3) @(posedge clk);
        #1;
        chk("hold_pc", pc, pc0);
        chk("hold_flags", flags, fl0);
        ce = 1'b1;
        @(posedge clk);
        #1;
        chk("resume_pc", pc, pc0 + 32'h0000_0004);
        $display("test enable done");
    endtask : t_enable
    // ==========================================
    // Run control
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    initial begin
        #20000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_branch();
        t_jump();
        t_interlock();
        t_memory();
        t_decode();
        t_cond();
        t_enable();
        stop_test();
    end
endmodule : scalar_pipeline_control_tb_top
`default_nettype wire
